// ===== verilog/tgm_timer_watchdog.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module tgm_timer_watchdog
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [23:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System side
    input wire logic slow_clock,
    input wire tgm_pkg::tgm_mode_e power_mode,
    output logic periodic_pulse,
    output logic periodic_interrupt_line,
    output logic watchdog_reset_req
);

////////////////////////////////////////////////////////////////////////////

function automatic logic [4:0] last_count(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h00;
    unique case (code)
        3'h0: r = 5'h00;
        3'h1: r = 5'h01;
        3'h2: r = 5'h03;
        3'h3: r = 5'h07;
        3'h4: r = 5'h0f;
        3'h5: r = 5'h1f;
        default: r = 5'h00;
    endcase
    return r;
endfunction

logic [2:0] slow_sync;
logic slow_level;
logic [4:0] pre_cnt;
logic [2:0] prescale;
tgm_pkg::tgm_cfg_s cfg;
logic [15:0] reload;
logic [15:0] tmr_cnt;
logic restart;
logic tc;
logic irq_en;
logic [7:0] wdcount;
logic wd_on;
logic [7:0] wd_cnt;
logic wd_clocked;

////////////////////////////////////////////////////////////////////////////
// Slow clock edge detection and prescaler.

// The slow clock is only sampled; its rising edges become one-cycle enables.
wire slow_stable = slow_sync[1] == slow_sync[2];
wire slow_rise = slow_stable && slow_sync[2] && !slow_level;
wire running = power_mode != tgm_pkg::MODE_HALT;
wire slow_edge = slow_rise && running;
// Using >= keeps the divider sane when the code shrinks mid-count.
wire tick = slow_edge && (pre_cnt >= last_count(prescale));
wire [4:0] next_pre_cnt = tick ? 5'h00 : pre_cnt + 5'h01;

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        slow_sync <= 3'h0;
        slow_level <= 1'b0;
        pre_cnt <= 5'h00;
    end
    else
    begin
        slow_sync <= {slow_sync[1:0], slow_clock};
        if (slow_stable)
            slow_level <= slow_sync[2];
        if (slow_edge)
            pre_cnt <= next_pre_cnt;
    end
end

////////////////////////////////////////////////////////////////////////////
// APB decode.

wire access = psel && penable && pready;
wire is_active = power_mode == tgm_pkg::MODE_ACTIVE;
wire at_cfg = paddr == tgm_pkg::CONFIG_ADDR;
wire at_pre = paddr == tgm_pkg::PRESCALE_ADDR;
wire at_rld = paddr == tgm_pkg::RELOAD_ADDR;
wire at_csr = paddr == tgm_pkg::CTRL_ADDR;
wire at_wdc = paddr == tgm_pkg::WDCOUNT_ADDR;
wire at_mat = paddr == tgm_pkg::MATCH_ADDR;
wire mapped = at_cfg || at_pre || at_rld || at_csr || at_wdc || at_mat;
wire wr = access && pwrite;
// Only the match register stays reachable outside active mode, and not in halt.
wire wr_reach = wr && is_active;
wire wr_cfg = wr_reach && at_cfg && !cfg.lock[tgm_pkg::CFG_LOCK_CONFIG];
wire wr_pre = wr_reach && at_pre
    && !cfg.lock[tgm_pkg::CFG_LOCK_PRESCALE];
wire timer_open = !cfg.lock[tgm_pkg::CFG_LOCK_TIMER];
wire wr_rld = wr_reach && at_rld && timer_open;
wire wr_csr = wr_reach && at_csr && timer_open;
wire wr_wdc = wr_reach && at_wdc
    && !cfg.lock[tgm_pkg::CFG_LOCK_WDCOUNT];
wire wr_mat = wr && at_mat && running;

// Locked or unreachable registers read as zero.
wire rd_ok = is_active;
wire [7:0] rd_cfg = cfg.lock[tgm_pkg::CFG_LOCK_CONFIG] ? 8'h00
    : {2'b00, cfg};
wire [7:0] rd_pre = cfg.lock[tgm_pkg::CFG_LOCK_PRESCALE] ? 8'h00
    : {5'h00, prescale};
wire [15:0] rd_rld = timer_open ? reload : 16'h0000;
wire [7:0] rd_csr = timer_open ? {5'h00, irq_en, tc, restart} : 8'h00;
wire [7:0] rd_wdc = cfg.lock[tgm_pkg::CFG_LOCK_WDCOUNT] ? 8'h00 : wdcount;
wire [31:0] rd_data = !rd_ok ? 32'h0000_0000
    : at_cfg ? {24'h00_0000, rd_cfg}
    : at_pre ? {24'h00_0000, rd_pre}
    : at_rld ? {16'h0000, rd_rld}
    : at_csr ? {24'h00_0000, rd_csr}
    : at_wdc ? {24'h00_0000, rd_wdc}
    : 32'h0000_0000;

// Every transfer gets one access cycle; answers are prepared in setup.
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= psel && !penable && !pready;
        prdata <= rd_data;
        pslverr <= psel && !penable && !mapped;
    end
end

////////////////////////////////////////////////////////////////////////////
// Configuration, prescaler and reload registers.

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cfg <= '0;
        prescale <= tgm_pkg::PRESCALE_RST;
        reload <= tgm_pkg::RELOAD_RST;
        wdcount <= tgm_pkg::WDCOUNT_RST;
    end
    else
    begin
        if (wr_cfg)
        begin
            // Lock bits only ever gain ones.
            cfg.lock <= cfg.lock | pwdata[3:0];
            cfg.tick_sel <= pwdata[tgm_pkg::CFG_TICK_SEL];
            cfg.match_sel <= pwdata[tgm_pkg::CFG_MATCH_SEL];
        end
        if (wr_pre)
            prescale <= pwdata[2:0];
        if (wr_rld)
            reload <= pwdata[15:0];
        if (wr_wdc)
            wdcount <= pwdata[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////
// Periodic timer.

wire reload_now = restart || (tmr_cnt == 16'h0000);
wire [15:0] next_tmr = reload_now ? reload
    : tmr_cnt - 16'h0001;
wire hit = next_tmr == 16'h0000;
wire next_pulse = tick ? hit : periodic_pulse;

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tmr_cnt <= tgm_pkg::TIMER_RST;
        periodic_pulse <= 1'b0;
        periodic_interrupt_line <= 1'b0;
        restart <= 1'b0;
        tc <= 1'b0;
        irq_en <= 1'b0;
    end
    else
    begin
        if (tick)
            tmr_cnt <= next_tmr;
        periodic_pulse <= next_pulse;
        periodic_interrupt_line <= next_pulse && irq_en;
        // A new request made on the tick itself survives to the next one.
        restart <= (wr_csr && pwdata[tgm_pkg::CSR_RESTART])
            || (restart && !tick);
        // The flag is cleared by writing one; a new hit wins.
        tc <= (tick && hit)
            || (tc && !(wr_csr && pwdata[tgm_pkg::CSR_TC]));
        if (wr_csr)
            irq_en <= pwdata[tgm_pkg::CSR_IRQ_EN];
    end
end

////////////////////////////////////////////////////////////////////////////
// Watchdog.

wire key_ok = pwdata[7:0] == tgm_pkg::SERVICE_KEY;
wire svc_count = wr_wdc && !cfg.match_sel;
wire svc_match = wr_mat && cfg.match_sel && key_ok;
wire bad_key = wr_mat && cfg.match_sel && !key_ok;
wire start = !wd_on && (wr_wdc || wr_mat);
wire service = wd_on && (svc_count || svc_match);
wire wd_ev = wd_on
    && (cfg.tick_sel ? tick : (tick && hit));
// Too often: a service with no watchdog clock since the start or the last service.
wire too_often = service && !wd_clocked;
wire too_late = wd_ev && !service && (wd_cnt <= 8'h01);
wire [7:0] start_val = wr_wdc ? pwdata[7:0] : wdcount;
wire [7:0] svc_val = svc_count ? pwdata[7:0] : wdcount;

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        wd_on <= 1'b0;
        wd_cnt <= tgm_pkg::WDCOUNT_RST;
        wd_clocked <= 1'b0;
        watchdog_reset_req <= 1'b0;
    end
    else
    begin
        // Nothing but presetn ever drops wd_on.
        if (start)
            wd_on <= 1'b1;
        if (start)
            wd_cnt <= start_val;
        else if (service)
            wd_cnt <= svc_val;
        else if (wd_ev && wd_cnt != 8'h00)
            wd_cnt <= wd_cnt - 8'h01;
        if (start || service)
            wd_clocked <= 1'b0;
        else if (wd_ev)
            wd_clocked <= 1'b1;
        // Held until the system reset it requests clears it.
        watchdog_reset_req <= watchdog_reset_req || too_often
            || too_late || bad_key;
    end
end

////////////////////////////////////////////////////////////////////////////
// Checks.

a_restart_done: assert property (
    @(posedge pclk) disable iff (!presetn)
    restart && tick |=> !restart || $past(wr_csr))
    else $error("restart bit not cleared at tick");

a_restart_loads: assert property (
    @(posedge pclk) disable iff (!presetn)
    restart && tick |=> tmr_cnt == $past(reload))
    else $error("restart did not reload timer");

a_count_down: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && !restart && tmr_cnt != 16'h0000
    |=> tmr_cnt == $past(tmr_cnt) - 16'h0001)
    else $error("timer did not decrement on tick");

a_zero_reloads: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && tmr_cnt == 16'h0000 |=> tmr_cnt == $past(reload))
    else $error("timer did not reload at zero");

a_pulse_sets_tc: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(periodic_pulse) |-> tc)
    else $error("pulse without terminal count flag");

a_irq_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    periodic_interrupt_line |-> periodic_pulse && $past(irq_en))
    else $error("interrupt without pulse or enable");

a_lock_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(cfg.lock) & ~cfg.lock) == 4'h0)
    else $error("lock bit cleared");

a_locked_reload: assert property (
    @(posedge pclk) disable iff (!presetn)
    !timer_open |=> $stable(reload))
    else $error("locked reload register changed");

a_wd_stays_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    wd_on |=> wd_on)
    else $error("watchdog stopped without reset");

a_wd_idle_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wd_on && !start |=> !watchdog_reset_req)
    else $error("watchdog error while disabled");

a_bad_key_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    bad_key |=> watchdog_reset_req)
    else $error("wrong key did not raise error");

a_halt_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !running |=> $stable(tmr_cnt) && $stable(wd_cnt)
    && $stable(pre_cnt))
    else $error("counters moved during halt");

a_pulse_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tick |=> $stable(periodic_pulse))
    else $error("pulse changed between ticks");

a_late_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    too_late |=> watchdog_reset_req)
    else $error("late service did not raise error");

a_error_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    watchdog_reset_req |=> watchdog_reset_req)
    else $error("reset request dropped");

a_cfg_locked: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg.lock[tgm_pkg::CFG_LOCK_CONFIG] |=> $stable(cfg))
    else $error("locked configuration changed");

c_timer_wrap: cover property (@(posedge pclk) disable iff (!presetn)
    tick && tmr_cnt == 16'h0000);

c_match_service: cover property (@(posedge pclk) disable iff (!presetn)
    svc_match);

c_wd_late: cover property (@(posedge pclk) disable iff (!presetn)
    too_late);

c_too_often: cover property (@(posedge pclk) disable iff (!presetn)
    too_often);

c_wrong_key: cover property (@(posedge pclk) disable iff (!presetn)
    bad_key);

endmodule

// ===== verilog/tgm_pkg.sv
package tgm_pkg;

    localparam int ADDR_W = 24;

    // Register byte addresses.
    localparam logic [23:0] CONFIG_ADDR = 24'hffa000;
    localparam logic [23:0] PRESCALE_ADDR = 24'hffa004;
    localparam logic [23:0] RELOAD_ADDR = 24'hffa008;
    localparam logic [23:0] CTRL_ADDR = 24'hffa00c;
    localparam logic [23:0] WDCOUNT_ADDR = 24'hffa010;
    localparam logic [23:0] MATCH_ADDR = 24'hffa014;

    // Configuration register field positions.
    localparam int CFG_LOCK_CONFIG = 0;
    localparam int CFG_LOCK_PRESCALE = 1;
    localparam int CFG_LOCK_TIMER = 2;
    localparam int CFG_LOCK_WDCOUNT = 3;
    localparam int CFG_TICK_SEL = 4;
    localparam int CFG_MATCH_SEL = 5;

    // Timer control and status field positions.
    localparam int CSR_RESTART = 0;
    localparam int CSR_TC = 1;
    localparam int CSR_IRQ_EN = 2;

    // Values after reset.
    localparam logic [15:0] RELOAD_RST = 16'hffff;
    localparam logic [15:0] TIMER_RST = 16'hffff;
    localparam logic [2:0] PRESCALE_RST = 3'h0;
    localparam logic [7:0] WDCOUNT_RST = 8'h00;

    localparam logic [7:0] SERVICE_KEY = 8'h5c;

    typedef struct packed {
        logic match_sel;
        logic tick_sel;
        logic [3:0] lock;
    } tgm_cfg_s;

    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_POWER_SAVE,
        MODE_IDLE,
        MODE_HALT
    } tgm_mode_e;

endpackage

// ===== sim/tgm_testbench.sv
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [23:0] paddr = 24'h000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slow_clock = 1'b0;
    tgm_pkg::tgm_mode_e power_mode = tgm_pkg::MODE_ACTIVE;
    logic periodic_pulse;
    logic periodic_interrupt_line;
    logic watchdog_reset_req;
    int bad_count = 0;
    int tests_run = 0;
    int slow_cnt = 0;
    logic [2:0] slow_div = 3'h0;
    logic [31:0] rd;
    logic er;
    int t0;
    localparam logic [23:0] A_CFG = tgm_pkg::CONFIG_ADDR;
    localparam logic [23:0] A_PRE = tgm_pkg::PRESCALE_ADDR;
    localparam logic [23:0] A_REL = tgm_pkg::RELOAD_ADDR;
    localparam logic [23:0] A_CSR = tgm_pkg::CTRL_ADDR;
    localparam logic [23:0] A_WDC = tgm_pkg::WDCOUNT_ADDR;
    localparam logic [23:0] A_MAT = tgm_pkg::MATCH_ADDR;

    tgm_timer_watchdog i_tgm_timer_watchdog (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_clock(slow_clock), .power_mode(power_mode),
        .periodic_pulse(periodic_pulse),
        .periodic_interrupt_line(periodic_interrupt_line),
        .watchdog_reset_req(watchdog_reset_req));

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    // Slow clock of eight pclk periods; its rises are counted for timing.
    always @(posedge pclk)
    begin
        slow_div <= slow_div + 3'h1;
        if (slow_div == 3'h3)
        begin
            slow_clock <= 1'b1;
            slow_cnt <= slow_cnt + 1;
        end
        if (slow_div == 3'h7)
            slow_clock <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // An idle edge precedes every setup so psel never changes twice at once.
    task automatic apb(input logic w, input logic [23:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("pready", {31'h0, pready}, 32'h1);
    endtask

    task automatic wait_rise;
        int n;
        logic prev;
        logic cur;
        n = 0;
        cur = periodic_pulse;
        do
        begin
            prev = cur;
            @(posedge pclk);
            n++;
            cur = periodic_pulse;
        end while (!(cur === 1'b1 && prev !== 1'b1) && n < 3000);
        check("pulse seen", n < 3000, 1);
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic expect_wd(input int quiet, input int limit);
        repeat (quiet) @(posedge pclk);
        check("wd quiet", watchdog_reset_req, 0);
        repeat (limit) @(posedge pclk);
        check("wd error", watchdog_reset_req, 1);
        do_reset();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        apb(0, A_REL, 0);
        check("reload", rd, 32'h0000ffff);
        apb(0, A_CFG, 0);
        check("config", rd, 0);
        apb(0, 24'hffa020, 0);
        check("unmapped err", er, 1);
    endtask

    task automatic test_divisors;
        for (int c = 0; c < 6; c++)
        begin
            apb(1, A_PRE, c);
            apb(1, A_REL, 1);
            apb(1, A_CSR, 32'h5);
            wait_rise();
            check("irq", periodic_interrupt_line, 1);
            t0 = slow_cnt;
            wait_rise();
            check("period", slow_cnt - t0, 2 << c);
            apb(0, A_CSR, 0);
            check("csr", rd, 32'h6);
        end
    endtask

    task automatic test_reload_change;
        apb(1, A_PRE, 0);
        apb(1, A_REL, 3);
        wait_rise();
        wait_rise();
        t0 = slow_cnt;
        // Two ticks on, the count is mid-period, so the write must wait.
        repeat (16) @(posedge pclk);
        apb(1, A_REL, 1);
        wait_rise();
        check("old period", slow_cnt - t0, 4);
        t0 = slow_cnt;
        wait_rise();
        check("new period", slow_cnt - t0, 2);
    endtask

    task automatic test_modes;
        // The last restart lies far behind, so power-save may be entered.
        power_mode <= tgm_pkg::MODE_POWER_SAVE;
        apb(1, A_REL, 7);
        power_mode <= tgm_pkg::MODE_IDLE;
        apb(0, A_REL, 0);
        check("idle read", rd, 0);
        wait_rise();
        power_mode <= tgm_pkg::MODE_HALT;
        repeat (4) @(posedge pclk);
        rd[0] = periodic_pulse;
        repeat (200) @(posedge pclk);
        check("halt frozen", periodic_pulse, rd[0]);
        power_mode <= tgm_pkg::MODE_ACTIVE;
        apb(0, A_REL, 0);
        check("reload kept", rd, 1);
    endtask

    task automatic test_locks;
        apb(1, A_CFG, 32'h04);
        apb(1, A_REL, 5);
        apb(0, A_REL, 0);
        check("locked read", rd, 0);
        apb(1, A_CFG, 0);
        apb(0, A_CFG, 0);
        check("sticky lock", rd, 32'h04);
        apb(1, A_CFG, 32'h01);
        apb(1, A_CFG, 32'h30);
        apb(0, A_CFG, 0);
        check("cfg locked", rd, 0);
        do_reset();
        apb(0, A_REL, 0);
        check("lock cleared", rd, 32'h0000ffff);
    endtask

    task automatic test_watchdog;
        check("wd idle", watchdog_reset_req, 0);
        apb(1, A_CFG, 32'h10);
        apb(1, A_WDC, 32'h10);
        repeat (40) @(posedge pclk);
        apb(1, A_WDC, 32'h10);
        apb(1, A_CFG, 32'h30);
        expect_wd(80, 120);
        apb(1, A_REL, 1);
        apb(1, A_CSR, 32'h1);
        apb(1, A_WDC, 3);
        expect_wd(36, 100);
        apb(1, A_CFG, 32'h30);
        apb(1, A_MAT, 32'h33);
        expect_wd(0, 10);
        apb(1, A_CFG, 32'h30);
        apb(1, A_WDC, 32'h20);
        repeat (40) @(posedge pclk);
        apb(1, A_MAT, 32'h5c);
        repeat (40) @(posedge pclk);
        // Clocking from the idle timer pulse stops all watchdog events, so
        // the second of two quick services is surely too often.
        apb(1, A_CFG, 32'h20);
        apb(1, A_MAT, tgm_pkg::SERVICE_KEY);
        repeat (4) @(posedge pclk);
        check("serviced", watchdog_reset_req, 0);
        apb(1, A_MAT, 32'h5c);
        expect_wd(0, 10);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset_values();
        test_divisors();
        test_reload_change();
        test_modes();
        test_locks();
        test_watchdog();
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end
endmodule
